// ==== hw/npcr_pkg.sv ====
// Package for the protocol configuration register bank.
// Assumes byte addressing on the register bus, one word per register.
package npcr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_PASSIVE = 4'h8;
    localparam logic [3:0] IDX_STREAM = 4'h9;
    localparam logic [3:0] IDX_AUX = 4'hA;
    localparam logic [3:0] IDX_STATUS = 4'hF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PASSIVE_MASK = 8'hFD;
    localparam logic [7:0] STREAM_MASK = 8'h7F;
    localparam logic [7:0] AUX_MASK = 8'hBF;

    // Passive target register fields
    localparam int FDT_TRIM_LSB = 4;
    localparam int FDT_TRIM_W = 4;
    localparam int AP2P_BIT = 3;
    localparam int SENSF_BIT = 2;
    localparam int ANTICOLL_BIT = 0;

    // Stream mode register fields
    localparam int SCF_LSB = 5;
    localparam int SCP_LSB = 3;
    localparam int STX_LSB = 0;

    // Auxiliary register fields
    localparam int CRC_SKIP_BIT = 7;
    localparam int UID_LSB = 4;
    localparam int PHASE90_BIT = 3;
    localparam int CORR_DIS_BIT = 2;
    localparam int FON_N_LSB = 0;

    // Status register fields
    localparam int ST_FRAME_BIT = 0;
    localparam int ST_PEND_BIT = 1;
    localparam int ST_RSVD_BIT = 2;

    // Sub-carrier frequency codes
    localparam logic [1:0] SCF_BPSK_16 = 2'h0;
    localparam logic [1:0] SCF_SUB_32 = 2'h1;
    // Pulse count codes
    localparam logic [1:0] SCP_PULSE_4 = 2'h2;
    localparam logic [1:0] SCP_PULSE_8 = 2'h3;
    // Tx modulator period codes
    localparam logic [2:0] STX_DIV_128 = 3'h0;
    localparam logic [2:0] STX_DIV_64 = 3'h1;
    localparam logic [2:0] STX_DIV_32 = 3'h2;
    localparam logic [2:0] STX_DIV_16 = 3'h3;
    // UID size codes
    localparam logic [1:0] UID_4_BYTES = 2'h0;
    localparam logic [1:0] UID_7_BYTES = 2'h1;
    localparam logic [3:0] UID_LEN_4 = 4'h4;
    localparam logic [3:0] UID_LEN_7 = 4'h7;

    // Carrier divider ratios and pulse counts
    localparam logic [7:0] DIV_128 = 8'h80;
    localparam logic [7:0] DIV_64 = 8'h40;
    localparam logic [7:0] DIV_32 = 8'h20;
    localparam logic [7:0] DIV_16 = 8'h10;
    localparam logic [3:0] PULSES_4 = 4'h4;
    localparam logic [3:0] PULSES_8 = 4'h8;

    // Frame delay width in carrier periods
    localparam int FDT_W = 16;

endpackage

// ==== hw/npcr_fdt_trim.sv ====
// Frame delay trim: nominal delay minus the trim in carrier periods.
// Assumes nominal delay comes from logic on the same clock.
`timescale 1ns/1ps
module npcr_fdt_trim (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Delay values in carrier periods
    input wire logic [npcr_pkg::FDT_W-1:0] fdt_nominal,
    input wire logic [npcr_pkg::FDT_TRIM_W-1:0] fdt_trim,
    output logic [npcr_pkg::FDT_W-1:0] fdt_eff
);

    typedef struct packed {
        logic [npcr_pkg::FDT_W-1:0] fdt;
    } npcr_trim_s;

    npcr_trim_s st_reg;
    npcr_trim_s st_next;

    // Shorten delay, saturating at zero
    always_comb begin
        st_next = st_reg;
        if (fdt_nominal > npcr_pkg::FDT_W'(fdt_trim)) begin
            st_next.fdt = fdt_nominal - npcr_pkg::FDT_W'(fdt_trim);
        end else begin
            st_next.fdt = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fdt_eff = st_reg.fdt;

endmodule

// ==== hw/npcr_stream_decode.sv ====
// Decoder of stream mode settings into divider ratios and pulse count.
// Assumes the settings are stable flop outputs on the same clock.
`timescale 1ns/1ps
module npcr_stream_decode (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Stream mode fields
    input wire logic [1:0] subcarrier_freq_sel,
    input wire logic [1:0] subcarrier_pulse_count,
    input wire logic [2:0] stream_tx_period,
    // Decoded values
    output logic [7:0] subcarrier_div,
    output logic bpsk_mode,
    output logic [3:0] pulse_count,
    output logic [7:0] tx_period_div,
    output logic stream_rsvd
);

    typedef struct packed {
        logic [7:0] sc_div;
        logic bpsk;
        logic [3:0] pulses;
        logic [7:0] tx_div;
        logic rsvd;
    } npcr_dec_s;

    npcr_dec_s st_reg;
    npcr_dec_s st_next;

    // Decode each field, flag reserved codes
    always_comb begin
        st_next = '0;
        case (subcarrier_freq_sel)
            npcr_pkg::SCF_BPSK_16: begin
                st_next.sc_div = npcr_pkg::DIV_16;
                st_next.bpsk = 1'b1;
            end
            npcr_pkg::SCF_SUB_32: st_next.sc_div = npcr_pkg::DIV_32;
            default: st_next.rsvd = 1'b1;
        endcase
        case (subcarrier_pulse_count)
            npcr_pkg::SCP_PULSE_4: st_next.pulses = npcr_pkg::PULSES_4;
            npcr_pkg::SCP_PULSE_8: st_next.pulses = npcr_pkg::PULSES_8;
            default: st_next.rsvd = 1'b1;
        endcase
        case (stream_tx_period)
            npcr_pkg::STX_DIV_128: st_next.tx_div = npcr_pkg::DIV_128;
            npcr_pkg::STX_DIV_64: st_next.tx_div = npcr_pkg::DIV_64;
            npcr_pkg::STX_DIV_32: st_next.tx_div = npcr_pkg::DIV_32;
            npcr_pkg::STX_DIV_16: st_next.tx_div = npcr_pkg::DIV_16;
            default: st_next.rsvd = 1'b1;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign subcarrier_div = st_reg.sc_div;
    assign bpsk_mode = st_reg.bpsk;
    assign pulse_count = st_reg.pulses;
    assign tx_period_div = st_reg.tx_div;
    assign stream_rsvd = st_reg.rsvd;

endmodule

// ==== hw/npcr_config_regs.sv ====
// Protocol configuration register bank with an Avalon-MM slave.
// Assumes frame_active and the protocol strobes come from core logic
// on ref_clk; settings reach the core only between frames.
`timescale 1ns/1ps

module npcr_config_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core status
    input wire logic frame_active,
    input wire logic reqa_wupa_direct,
    input wire logic anticoll_frame_sel,
    input wire logic [npcr_pkg::FDT_W-1:0] fdt_nominal,
    // Passive target controls
    output logic [npcr_pkg::FDT_W-1:0] fdt_eff,
    output logic ap2p_recog_en,
    output logic auto_sensf_en,
    output logic auto_anticoll_en,
    output logic target_fifo_only,
    // Stream mode controls
    output logic [7:0] subcarrier_div,
    output logic bpsk_mode,
    output logic [3:0] pulse_count,
    output logic [7:0] tx_period_div,
    // Receive and auxiliary controls
    output logic rx_crc_check_en,
    output logic [3:0] uid_len,
    output logic phase_clock_shift90,
    output logic correlator_en,
    output logic [1:0] field_on_n_value
);

    typedef struct packed {
        logic [7:0] passive;
        logic [7:0] stream;
        logic [7:0] aux;
        logic [7:0] passive_act;
        logic [7:0] stream_act;
        logic [7:0] aux_act;
        logic ack;
        logic [7:0] rdata;
    } npcr_state_s;

    npcr_state_s st_reg;
    npcr_state_s st_next;

    logic stream_rsvd;
    logic aux_rsvd;
    logic pending;
    logic req;
    logic [3:0] idx;

    // Register index from byte address
    function automatic logic [3:0] npcr_index(input logic [5:0] addr);
        npcr_index = addr[5:2];
    endfunction

    // Readback value for an index
    function automatic logic [7:0] npcr_read(
        input logic [3:0] i,
        input npcr_state_s s,
        input logic [7:0] status
    );
        case (i)
            npcr_pkg::IDX_PASSIVE: npcr_read = s.passive;
            npcr_pkg::IDX_STREAM: npcr_read = s.stream;
            npcr_pkg::IDX_AUX: npcr_read = s.aux;
            npcr_pkg::IDX_STATUS: npcr_read = status;
            default: npcr_read = 8'h00;
        endcase
    endfunction

    // Request decode
    assign req = avs_read | avs_write;
    assign idx = npcr_index(avs_address);

    // Stored settings not yet applied to the core
    assign pending = (st_reg.passive != st_reg.passive_act)
        | (st_reg.stream != st_reg.stream_act)
        | (st_reg.aux != st_reg.aux_act);

    // Reserved identifier size or correlator code in use
    assign aux_rsvd = st_reg.aux_act[npcr_pkg::UID_LSB+1]
        | st_reg.aux_act[npcr_pkg::CORR_DIS_BIT];

    // Bus slave, register storage and frame-aligned apply
    always_comb begin
        logic [7:0] status;
        status = 8'h00;
        status[npcr_pkg::ST_FRAME_BIT] = frame_active;
        status[npcr_pkg::ST_PEND_BIT] = pending;
        status[npcr_pkg::ST_RSVD_BIT] = stream_rsvd | aux_rsvd;
        st_next = st_reg;
        // One wait cycle, then answer
        st_next.ack = req & ~st_reg.ack;
        st_next.rdata = npcr_read(idx, st_reg, status);
        // Write lands on the edge where waitrequest is low
        if (avs_write && st_reg.ack && avs_byteenable[0]) begin
            case (idx)
                npcr_pkg::IDX_PASSIVE:
                    st_next.passive = avs_writedata[7:0] & npcr_pkg::PASSIVE_MASK;
                npcr_pkg::IDX_STREAM:
                    st_next.stream = avs_writedata[7:0] & npcr_pkg::STREAM_MASK;
                npcr_pkg::IDX_AUX:
                    st_next.aux = avs_writedata[7:0] & npcr_pkg::AUX_MASK;
                default: st_next.aux = st_reg.aux;
            endcase
        end
        // Settings reach the core only between frames
        if (!frame_active) begin
            st_next.passive_act = st_reg.passive;
            st_next.stream_act = st_reg.stream;
            st_next.aux_act = st_reg.aux;
        end
    end

    // State register, all fields zero at reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus answer
    assign avs_waitrequest = req & ~st_reg.ack;
    assign avs_readdata = {24'h000000, st_reg.rdata};

    // Frame delay trim in card emulation
    npcr_fdt_trim u_trim (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .fdt_nominal(fdt_nominal),
        .fdt_trim(st_reg.passive_act[npcr_pkg::FDT_TRIM_LSB +: npcr_pkg::FDT_TRIM_W]),
        .fdt_eff(fdt_eff)
    );

    // Stream mode decode
    npcr_stream_decode u_stream (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .subcarrier_freq_sel(st_reg.stream_act[npcr_pkg::SCF_LSB +: 2]),
        .subcarrier_pulse_count(st_reg.stream_act[npcr_pkg::SCP_LSB +: 2]),
        .stream_tx_period(st_reg.stream_act[npcr_pkg::STX_LSB +: 3]),
        .subcarrier_div(subcarrier_div),
        .bpsk_mode(bpsk_mode),
        .pulse_count(pulse_count),
        .tx_period_div(tx_period_div),
        .stream_rsvd(stream_rsvd)
    );

    // Passive target automatic responses
    assign ap2p_recog_en = ~st_reg.passive_act[npcr_pkg::AP2P_BIT];
    assign auto_sensf_en = ~st_reg.passive_act[npcr_pkg::SENSF_BIT];
    assign auto_anticoll_en = ~st_reg.passive_act[npcr_pkg::ANTICOLL_BIT];
    // A disabled SENSF or anticollision automatic hands target traffic to the FIFO
    assign target_fifo_only = ~auto_sensf_en | ~auto_anticoll_en;

    // Receive CRC check, forced off for short frames
    assign rx_crc_check_en = ~st_reg.aux_act[npcr_pkg::CRC_SKIP_BIT]
        & ~reqa_wupa_direct & ~anticoll_frame_sel;

    // Identifier length in bytes
    always_comb begin
        case (st_reg.aux_act[npcr_pkg::UID_LSB +: 2])
            npcr_pkg::UID_4_BYTES: uid_len = npcr_pkg::UID_LEN_4;
            npcr_pkg::UID_7_BYTES: uid_len = npcr_pkg::UID_LEN_7;
            default: uid_len = npcr_pkg::UID_LEN_4;
        endcase
    end

    // Remaining auxiliary controls
    assign phase_clock_shift90 = st_reg.aux_act[npcr_pkg::PHASE90_BIT];
    assign correlator_en = ~st_reg.aux_act[npcr_pkg::CORR_DIS_BIT];
    assign field_on_n_value = st_reg.aux_act[npcr_pkg::FON_N_LSB +: 2];

endmodule

// ==== tb/npcr_config_regs_sva.sv ====
// Checker for bus handshake and control outputs of the config bank.
// Assumes it is bound to npcr_config_regs and sees its ports only.
`timescale 1ns/1ps
module npcr_config_regs_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Core side
    input wire logic frame_active,
    input wire logic reqa_wupa_direct,
    input wire logic anticoll_frame_sel,
    input wire logic [npcr_pkg::FDT_W-1:0] fdt_nominal,
    input wire logic [npcr_pkg::FDT_W-1:0] fdt_eff,
    input wire logic ap2p_recog_en,
    input wire logic auto_sensf_en,
    input wire logic auto_anticoll_en,
    input wire logic target_fifo_only,
    input wire logic [7:0] subcarrier_div,
    input wire logic bpsk_mode,
    input wire logic [7:0] tx_period_div,
    input wire logic rx_crc_check_en
);
    // Sampling on the core clock, quiet during reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // Bus handshake and read data
    wait_one_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
    idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait raised while idle");
    rd_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    // Control outputs against their causes
    crc_forced_a: assert property ((reqa_wupa_direct || anticoll_frame_sel)
        |-> !rx_crc_check_en) else $error("crc check during forced skip");
    fifo_only_a: assert property (target_fifo_only == (!auto_sensf_en || !auto_anticoll_en))
        else $error("fifo only mismatch");
    frame_hold_a: assert property ($past(frame_active)
        |-> $stable(ap2p_recog_en) && $stable(auto_sensf_en)) else $error("change inside frame");
    fdt_short_a: assert property (fdt_eff <= $past(fdt_nominal))
        else $error("delay above nominal");
    bpsk_div_a: assert property (bpsk_mode |-> subcarrier_div == 8'h10)
        else $error("bpsk divider wrong");
    tx_div_set_a: assert property (tx_period_div inside {8'h00, 8'h10, 8'h20, 8'h40, 8'h80})
        else $error("tx divider out of set");

    // Main scenarios
    cov_wr: cover property (avs_write && !avs_waitrequest);
    cov_rd: cover property (avs_read && !avs_waitrequest);
    cov_frame: cover property (frame_active ##1 !frame_active);
endmodule

bind npcr_config_regs npcr_config_regs_sva u_sva (.ref_clk(ref_clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_active(frame_active),
    .reqa_wupa_direct(reqa_wupa_direct), .anticoll_frame_sel(anticoll_frame_sel),
    .fdt_nominal(fdt_nominal), .fdt_eff(fdt_eff), .ap2p_recog_en(ap2p_recog_en),
    .auto_sensf_en(auto_sensf_en), .auto_anticoll_en(auto_anticoll_en),
    .target_fifo_only(target_fifo_only), .subcarrier_div(subcarrier_div),
    .bpsk_mode(bpsk_mode), .tx_period_div(tx_period_div), .rx_crc_check_en(rx_crc_check_en));

// ==== tb/testbench.sv ====
// Self-checking bench of the config bank over its Avalon-MM slave.
// Assumes the bench drives all core-side inputs itself.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic frame_active = 1'b0;
    logic reqa_wupa_direct = 1'b0;
    logic anticoll_frame_sel = 1'b0;
    logic [15:0] fdt_nominal = 16'h0100;
    logic [15:0] fdt_eff;
    logic ap2p_recog_en, auto_sensf_en, auto_anticoll_en, target_fifo_only;
    logic [7:0] subcarrier_div, tx_period_div, rd;
    logic bpsk_mode, rx_crc_check_en, phase_clock_shift90, correlator_en;
    logic [3:0] pulse_count, uid_len;
    logic [1:0] field_on_n_value;
    int bad_count = 0;
    int checks_done = 0;

    // Core clock, 100 MHz
    always #5 ref_clk = ~ref_clk;

    npcr_config_regs u_dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .frame_active(frame_active),
        .reqa_wupa_direct(reqa_wupa_direct), .anticoll_frame_sel(anticoll_frame_sel),
        .fdt_nominal(fdt_nominal), .fdt_eff(fdt_eff), .ap2p_recog_en(ap2p_recog_en),
        .auto_sensf_en(auto_sensf_en), .auto_anticoll_en(auto_anticoll_en),
        .target_fifo_only(target_fifo_only), .subcarrier_div(subcarrier_div),
        .bpsk_mode(bpsk_mode), .pulse_count(pulse_count), .tx_period_div(tx_period_div),
        .rx_crc_check_en(rx_crc_check_en), .uid_len(uid_len),
        .phase_clock_shift90(phase_clock_shift90), .correlator_en(correlator_en),
        .field_on_n_value(field_on_n_value));

    // One bus cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Lets a stored value reach the applied copy and the decoders
    task automatic settle;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 6'h20 + 6'(4 * i), 8'h00);
            `CHK("rst_val", 8'h00, rd)
        end
        `CHK("rst_en", 3'b111, {ap2p_recog_en, auto_sensf_en, auto_anticoll_en})
    endtask

    task automatic t_rw;
        logic [7:0] m [3];
        m = '{npcr_pkg::PASSIVE_MASK, npcr_pkg::STREAM_MASK, npcr_pkg::AUX_MASK};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 6'h20 + 6'(4 * i), 8'hFF);
            bus(1'b0, 6'h20 + 6'(4 * i), 8'h00);
            `CHK("rw_mask", m[i], rd)
            bus(1'b1, 6'h20 + 6'(4 * i), 8'h00);
        end
        // Unmapped place, then a write with no byte lane enabled
        bus(1'b1, 6'h30, 8'hFF);
        bus(1'b0, 6'h30, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        avs_byteenable <= 4'h0;
        bus(1'b1, 6'h20, 8'hFF);
        avs_byteenable <= 4'hF;
        bus(1'b0, 6'h20, 8'h00);
        `CHK("no_lane", 8'h00, rd)
    endtask

    task automatic t_passive;
        logic [7:0] v [4];
        v = '{8'h28, 8'h05, 8'hF0, 8'h00};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 6'h20, v[i]);
            settle;
            `CHK("fdt", 16'h0100 - 16'(v[i][7:4]), fdt_eff)
            `CHK("ap2p", ~v[i][3], ap2p_recog_en)
            `CHK("sensf", ~v[i][2], auto_sensf_en)
            `CHK("acoll", ~v[i][0], auto_anticoll_en)
            `CHK("fifo", v[i][2] | v[i][0], target_fifo_only)
        end
        // Short nominal delay: trim below, then above it
        fdt_nominal <= 16'h0003;
        bus(1'b1, 6'h20, 8'h20);
        settle;
        `CHK("fdt_small", 16'h0001, fdt_eff)
        bus(1'b1, 6'h20, 8'hF0);
        settle;
        `CHK("fdt_sat", 16'h0000, fdt_eff)
        fdt_nominal <= 16'h0100;
    endtask

    task automatic t_stream;
        logic [7:0] d;
        for (int i = 0; i < 128; i++) begin
            d = 8'(i);
            bus(1'b1, 6'h24, d);
            settle;
            `CHK("scdiv", d[6:5] == 0 ? 8'h10 : d[6:5] == 1 ? 8'h20 : 8'h00, subcarrier_div)
            `CHK("bpsk", d[6:5] == 2'h0, bpsk_mode)
            `CHK("pulse", d[4] ? (d[3] ? 4'h8 : 4'h4) : 4'h0, pulse_count)
            `CHK("txdiv", d[2] ? 8'h00 : 8'h80 >> d[1:0], tx_period_div)
        end
    endtask

    task automatic t_aux;
        logic [7:0] d;
        for (int i = 0; i < 256; i++) begin
            d = 8'(i);
            bus(1'b1, 6'h28, d);
            settle;
            `CHK("crc", ~d[7], rx_crc_check_en)
            `CHK("uid", d[5:4] == 2'h1 ? 4'h7 : 4'h4, uid_len)
            `CHK("ph90", d[3], phase_clock_shift90)
            `CHK("corr", ~d[2], correlator_en)
            `CHK("fon_n", d[1:0], field_on_n_value)
        end
        // CRC check enabled, then forced off by the core strobes
        bus(1'b1, 6'h28, 8'h00);
        settle;
        reqa_wupa_direct <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("crc_reqa", 1'b0, rx_crc_check_en)
        reqa_wupa_direct <= 1'b0;
        anticoll_frame_sel <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("crc_acol", 1'b0, rx_crc_check_en)
        anticoll_frame_sel <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK("crc_back", 1'b1, rx_crc_check_en)
    endtask

    task automatic t_frame;
        // Status: reserved stream code left applied, nothing pending
        bus(1'b0, 6'h3C, 8'h00);
        `CHK("st_idle", 8'h04, rd)
        frame_active <= 1'b1;
        bus(1'b1, 6'h20, 8'h08);
        settle;
        `CHK("in_frame", 1'b1, ap2p_recog_en)
        bus(1'b0, 6'h20, 8'h00);
        `CHK("stored", 8'h08, rd)
        bus(1'b0, 6'h3C, 8'h00);
        `CHK("st_frame", 8'h07, rd)
        frame_active <= 1'b0;
        settle;
        `CHK("after_frame", 1'b0, ap2p_recog_en)
        bus(1'b0, 6'h3C, 8'h00);
        `CHK("st_after", 8'h04, rd)
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset;
        t_rw;
        t_passive;
        t_stream;
        t_aux;
        t_frame;
        stop_test;
    end

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        #200000;
        bad_count++;
        stop_test;
    end
endmodule
